// ### core/mag_pkg.sv
// constants, types and tables for the magnetometer serial command engine
// Operation
// - each axis reading reported as 16 bits
// - sample rate selectable, 10 to 154 per second
// - link runs at 9600 or 19200 bit/s
// - configuration reloaded from nonvolatile store at power-up
// - startup message finished within 80 ms
// - addressed reply starts after fixed response delay
// - global replies staggered by unit identifier
// - escape then carriage return stops continuous output
// - characters framed 8 data, no parity, 1 stop
package mag_pkg;
	localparam int CLK_RATE_HZ = 20_000_000;
	localparam int MS_PER_S = 1000;
	localparam int BAUD_SLOW = 9600;
	localparam int BAUD_FAST = 19200;
	localparam logic [11:0] DIV_SLOW = 12'(CLK_RATE_HZ / BAUD_SLOW);
	localparam logic [11:0] DIV_FAST = 12'(CLK_RATE_HZ / BAUD_FAST);
	localparam int MS_CYCLES = CLK_RATE_HZ / MS_PER_S;
	localparam logic [3:0] FRAME_BITS = 4'hA;
	localparam logic [11:0] STARTUP_MS = 12'h032;
	localparam logic [11:0] RESP_GEN_MS = 12'h002;
	localparam logic [11:0] RESP_POLL_MS = 12'h003;
	localparam logic [11:0] GLOBAL_STEP_MS = 12'h028;
	localparam logic [6:0] GLOBAL_ID = 7'h63;
	localparam logic [6:0] MAX_UNIT_ID = 7'h62;
	localparam logic [6:0] RESET_UNIT_ID = 7'h00;
	localparam logic [3:0] RESET_RATE_SEL = 4'h1;
	localparam logic [3:0] MAX_RATE_SEL = 4'h9;
	localparam int RATE_COUNT = 10;
	localparam int RATE_SPS [RATE_COUNT] = '{10, 20, 25, 30, 40, 50, 60,
		100, 123, 154};
	localparam logic [7:0] CHAR_STAR = 8'h2A;
	localparam logic [7:0] CHAR_CR = 8'h0D;
	localparam logic [7:0] CHAR_ESC = 8'h1B;
	localparam logic [7:0] CHAR_ZERO = 8'h30;
	localparam logic [7:0] CHAR_NINE = 8'h39;
	localparam logic [7:0] CHAR_O = 8'h4F;
	localparam logic [7:0] CHAR_K = 8'h4B;
	localparam logic [7:0] CMD_POLL = 8'h50;
	localparam logic [7:0] CMD_CONT = 8'h43;
	localparam logic [7:0] CMD_RATE = 8'h52;
	localparam logic [7:0] CMD_IDENT = 8'h49;
	localparam logic [7:0] CMD_BAUD = 8'h42;
	localparam logic [7:0] ARG_SLOW = 8'h53;
	localparam logic [7:0] ARG_FAST = 8'h46;
	localparam logic [2:0] LAST_OK = 3'h2;
	localparam logic [2:0] LAST_DATA = 3'h6;
	typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_WAIT, ST_SEND} state_t;
	typedef enum logic {RP_OK, RP_DATA} reply_t;
endpackage

// ### core/serial_port.sv
// 8N1 asynchronous transmitter and receiver with selectable divider
`timescale 1ns/100ps
module serial_port (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// bit period in clock cycles
	input wire logic [11:0] div,
	// transmit side
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic tx_busy,
	output logic tx_line,
	// receive side
	input wire logic rx_en,
	input wire logic rx_line,
	output logic rx_valid,
	output logic [7:0] rx_data
);
	import mag_pkg::*;

	logic [9:0] tx_shift, next_tx_shift;
	logic [3:0] tx_bits, next_tx_bits;
	logic [11:0] tx_div, next_tx_div;
	logic next_tx_busy;
	logic rx_busy, next_rx_busy, next_rx_valid;
	logic [3:0] rx_bits, next_rx_bits;
	logic [11:0] rx_div, next_rx_div;
	logic [7:0] rx_shift, next_rx_shift, next_rx_data;

	assign tx_ready = !tx_busy;
	// shift register refills with ones, so the idle line is high
	assign tx_line = tx_shift[0];

	always_comb begin
		next_tx_busy = tx_busy;
		next_tx_shift = tx_shift;
		next_tx_bits = tx_bits;
		next_tx_div = tx_div;
		if (!tx_busy) begin
			if (tx_valid) begin
				next_tx_busy = 1'b1;
				next_tx_shift = {1'b1, tx_data, 1'b0};
				next_tx_bits = FRAME_BITS;
				next_tx_div = div - 12'h001;
			end
		end else if (tx_div == 12'h000) begin
			next_tx_div = div - 12'h001;
			next_tx_shift = {1'b1, tx_shift[9:1]};
			next_tx_bits = tx_bits - 4'h1;
			if (tx_bits == 4'h1) begin
				next_tx_busy = 1'b0;
			end
		end else begin
			next_tx_div = tx_div - 12'h001;
		end
	end

	always_comb begin
		next_rx_busy = rx_busy;
		next_rx_bits = rx_bits;
		next_rx_div = rx_div;
		next_rx_shift = rx_shift;
		next_rx_valid = 1'b0;
		next_rx_data = rx_data;
		if (!rx_busy) begin
			if (rx_en && !rx_line) begin
				next_rx_busy = 1'b1;
				next_rx_bits = FRAME_BITS;
				next_rx_div = {1'b0, div[11:1]};
			end
		end else if (rx_div != 12'h000) begin
			next_rx_div = rx_div - 12'h001;
		end else begin
			next_rx_div = div - 12'h001;
			next_rx_bits = rx_bits - 4'h1;
			if (rx_bits == FRAME_BITS && rx_line) begin
				next_rx_busy = 1'b0; // glitch, not a start bit
			end else if (rx_bits == 4'h1) begin
				next_rx_busy = 1'b0;
				next_rx_valid = rx_line;
				next_rx_data = rx_shift;
			end else if (rx_bits != FRAME_BITS) begin
				next_rx_shift = {rx_line, rx_shift[7:1]};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_busy <= 1'b0;
			tx_shift <= 10'h3FF;
			tx_bits <= 4'h0;
			tx_div <= 12'h000;
			rx_busy <= 1'b0;
			rx_bits <= 4'h0;
			rx_div <= 12'h000;
			rx_shift <= 8'h00;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
		end else begin
			tx_busy <= next_tx_busy;
			tx_shift <= next_tx_shift;
			tx_bits <= next_tx_bits;
			tx_div <= next_tx_div;
			rx_busy <= next_rx_busy;
			rx_bits <= next_rx_bits;
			rx_div <= next_rx_div;
			rx_shift <= next_rx_shift;
			rx_valid <= next_rx_valid;
			rx_data <= next_rx_data;
		end
	end

	property p_start_bit;
		@(posedge ref_clk) disable iff (sys_rst)
		$rose(tx_busy) |-> !tx_line ##1 !tx_line;
	endproperty
	a_start_bit: assert property (p_start_bit)
		else $error("start bit not driven low");
endmodule

// ### core/mag_engine.sv
// serial command and response engine of the three-axis magnetometer
`timescale 1ns/100ps
module mag_engine #(
	parameter int MS_CYCLES = mag_pkg::MS_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// serial link
	input wire logic serial_receive_line,
	output logic serial_transmit_line,
	output logic transmit_oe_n,
	input wire logic half_duplex,
	// nonvolatile configuration
	input wire logic [6:0] nv_unit_identifier,
	input wire logic [3:0] nv_rate_sel,
	input wire logic nv_baud_fast,
	output logic nv_write,
	output logic [6:0] unit_identifier,
	output logic [3:0] rate_sel,
	output logic baud_fast,
	// axis converter
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [15:0] axis_x,
	input wire logic [15:0] axis_y,
	input wire logic [15:0] axis_z
);
	import mag_pkg::*;

	// bit period follows the millisecond, so a short test millisecond
	// shortens characters too; at the default it is the true divider
	localparam logic [11:0] BIT_SLOW = 12'(MS_CYCLES * MS_PER_S / BAUD_SLOW);
	localparam logic [11:0] BIT_FAST = 12'(MS_CYCLES * MS_PER_S / BAUD_FAST);

	state_t st, next_st;
	reply_t kind, next_kind;
	logic [2:0] idx, next_idx, p_pos, next_p_pos;
	logic [11:0] wait_ms, next_wait_ms;
	logic [15:0] ms_cnt, next_ms_cnt;
	logic [6:0] p_id, next_p_id, p_arg, next_p_arg;
	logic [7:0] p_cmd, next_p_cmd, tx_byte;
	logic esc_seen, next_esc_seen, stream_on, next_stream_on;
	logic loaded, next_loaded, next_nv_write, link_fast, next_link_fast;
	logic [6:0] next_unit_identifier;
	logic [3:0] next_rate_sel;
	logic next_baud_fast, fire, is_digit, addressed, is_global;
	logic [3:0] dval;
	logic [23:0] rate_cnt, next_rate_cnt;
	logic [23:0] period_tab [RATE_COUNT];
	logic next_conv_start, new_sample, next_new_sample;
	logic [15:0] sample_x, sample_y, sample_z;
	logic tx_valid, tx_ready, tx_busy, rx_valid;
	logic [7:0] rx_data;

	serial_port link (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.div(link_fast ? BIT_FAST : BIT_SLOW),
		.tx_valid(tx_valid),
		.tx_data(tx_byte),
		.tx_ready(tx_ready),
		.tx_busy(tx_busy),
		.tx_line(serial_transmit_line),
		// half duplex: our own transmission must not be parsed back
		.rx_en(!(half_duplex && !transmit_oe_n)),
		.rx_line(serial_receive_line),
		.rx_valid(rx_valid),
		.rx_data(rx_data)
	);

	// full duplex keeps the driver on; half duplex releases it at once
	assign transmit_oe_n = half_duplex
		&& !(tx_busy || st == ST_SEND);
	assign tx_valid = (st == ST_SEND);

	for (genvar g = 0; g < RATE_COUNT; g++) begin : g_rate
		assign period_tab[g] = 24'(MS_CYCLES * MS_PER_S / RATE_SPS[g]);
	end

	always_comb begin
		case ({kind, idx})
			{RP_DATA, 3'h0}: tx_byte = sample_x[15:8];
			{RP_DATA, 3'h1}: tx_byte = sample_x[7:0];
			{RP_DATA, 3'h2}: tx_byte = sample_y[15:8];
			{RP_DATA, 3'h3}: tx_byte = sample_y[7:0];
			{RP_DATA, 3'h4}: tx_byte = sample_z[15:8];
			{RP_DATA, 3'h5}: tx_byte = sample_z[7:0];
			{RP_OK, 3'h0}: tx_byte = CHAR_O;
			{RP_OK, 3'h1}: tx_byte = CHAR_K;
			default: tx_byte = CHAR_CR;
		endcase
	end

	assign is_digit = rx_data >= CHAR_ZERO && rx_data <= CHAR_NINE;
	assign dval = rx_data[3:0];
	assign is_global = (p_id == GLOBAL_ID);
	assign addressed = is_global || p_id == unit_identifier;
	assign fire = rx_valid && p_pos == 3'h6 && rx_data == CHAR_CR
		&& !esc_seen && addressed && st == ST_IDLE;

	always_comb begin
		next_st = st;
		next_kind = kind;
		next_idx = idx;
		next_wait_ms = wait_ms;
		next_ms_cnt = ms_cnt;
		next_p_pos = p_pos;
		next_p_id = p_id;
		next_p_arg = p_arg;
		next_p_cmd = p_cmd;
		next_esc_seen = esc_seen;
		next_stream_on = stream_on;
		next_loaded = 1'b1;
		next_nv_write = 1'b0;
		next_unit_identifier = unit_identifier;
		next_rate_sel = rate_sel;
		next_baud_fast = baud_fast;
		next_link_fast = link_fast;
		next_new_sample = new_sample || (conv_done && st != ST_SEND);
		if (!loaded) begin
			// strap-like capture of the stored settings after reset
			next_unit_identifier = nv_unit_identifier;
			next_rate_sel = nv_rate_sel > MAX_RATE_SEL ? RESET_RATE_SEL
				: nv_rate_sel;
			next_baud_fast = nv_baud_fast;
			next_link_fast = nv_baud_fast;
		end
		if (rx_valid) begin
			next_esc_seen = (rx_data == CHAR_ESC);
			if (rx_data == CHAR_ESC) begin
				next_p_pos = 3'h0;
			end else begin
				if (esc_seen && rx_data == CHAR_CR) begin
					next_stream_on = 1'b0;
				end
				next_p_pos = 3'h0;
				case (p_pos)
					3'h0: if (rx_data == CHAR_STAR) begin
						next_p_pos = 3'h1;
					end
					3'h1: if (is_digit) begin
						next_p_id = 7'({3'h0, dval} * 7'h0A);
						next_p_pos = 3'h2;
					end
					3'h2: if (is_digit) begin
						next_p_id = p_id + {3'h0, dval};
						next_p_pos = 3'h3;
					end
					3'h3: begin
						next_p_cmd = rx_data;
						if (rx_data == CMD_POLL || rx_data == CMD_CONT) begin
							next_p_pos = 3'h6;
						end else if (rx_data == CMD_RATE || rx_data == CMD_BAUD
							|| rx_data == CMD_IDENT) begin
							next_p_pos = 3'h4;
						end
					end
					3'h4: if (p_cmd == CMD_RATE && is_digit) begin
						next_p_arg = {3'h0, dval};
						next_p_pos = 3'h6;
					end else if (p_cmd == CMD_IDENT && is_digit) begin
						next_p_arg = 7'({3'h0, dval} * 7'h0A);
						next_p_pos = 3'h5;
					end else if (p_cmd == CMD_BAUD && (rx_data == ARG_FAST
						|| rx_data == ARG_SLOW)) begin
						next_p_arg = {6'h00, rx_data == ARG_FAST};
						next_p_pos = 3'h6;
					end
					3'h5: if (is_digit) begin
						next_p_arg = p_arg + {3'h0, dval};
						next_p_pos = 3'h6;
					end
					default: next_p_pos = 3'h0;
				endcase
			end
		end
		case (st)
			ST_BOOT, ST_WAIT: begin
				next_ms_cnt = ms_cnt + 16'h0001;
				if (ms_cnt == 16'(MS_CYCLES - 1)) begin
					next_ms_cnt = 16'h0000;
					next_wait_ms = wait_ms - 12'h001;
					if (wait_ms == 12'h001) begin
						next_st = ST_SEND;
						next_idx = 3'h0;
					end
				end
			end
			ST_SEND: if (tx_ready) begin
				next_idx = idx + 3'h1;
				if (idx == (kind == RP_DATA ? LAST_DATA : LAST_OK)) begin
					next_st = ST_IDLE;
				end
			end
			default: begin
				if (!tx_busy) begin
					next_link_fast = baud_fast; // new rate after the OK reply
				end
				if (fire) begin
					next_st = ST_WAIT;
					next_ms_cnt = 16'h0000;
					next_kind = p_cmd == CMD_POLL ? RP_DATA : RP_OK;
					next_wait_ms = p_cmd == CMD_POLL ? RESP_POLL_MS
						: RESP_GEN_MS;
					if (is_global) begin
						next_wait_ms = next_wait_ms
							+ 12'({5'h00, unit_identifier} * GLOBAL_STEP_MS);
					end
					if (p_cmd == CMD_CONT) begin
						next_stream_on = 1'b1;
						next_st = ST_IDLE;
					end else if (p_cmd == CMD_RATE && p_arg <= 7'(MAX_RATE_SEL)) begin
						next_rate_sel = p_arg[3:0];
						next_nv_write = 1'b1;
					end else if (p_cmd == CMD_IDENT && p_arg <= MAX_UNIT_ID) begin
						next_unit_identifier = p_arg;
						next_nv_write = 1'b1;
					end else if (p_cmd == CMD_BAUD) begin
						next_baud_fast = p_arg[0];
						next_nv_write = 1'b1;
					end
				end else if (stream_on && new_sample) begin
					next_st = ST_SEND;
					next_kind = RP_DATA;
					next_idx = 3'h0;
					next_new_sample = conv_done;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st <= ST_BOOT;
			kind <= RP_OK;
			idx <= 3'h0;
			wait_ms <= STARTUP_MS;
			ms_cnt <= 16'h0000;
			p_pos <= 3'h0;
			p_id <= 7'h00;
			p_arg <= 7'h00;
			p_cmd <= 8'h00;
			esc_seen <= 1'b0;
			stream_on <= 1'b0;
			loaded <= 1'b0;
			nv_write <= 1'b0;
			unit_identifier <= RESET_UNIT_ID;
			rate_sel <= RESET_RATE_SEL;
			baud_fast <= 1'b0;
			link_fast <= 1'b0;
			new_sample <= 1'b0;
		end else begin
			st <= next_st;
			kind <= next_kind;
			idx <= next_idx;
			wait_ms <= next_wait_ms;
			ms_cnt <= next_ms_cnt;
			p_pos <= next_p_pos;
			p_id <= next_p_id;
			p_arg <= next_p_arg;
			p_cmd <= next_p_cmd;
			esc_seen <= next_esc_seen;
			stream_on <= next_stream_on;
			loaded <= next_loaded;
			nv_write <= next_nv_write;
			unit_identifier <= next_unit_identifier;
			rate_sel <= next_rate_sel;
			baud_fast <= next_baud_fast;
			link_fast <= next_link_fast;
			new_sample <= next_new_sample;
		end
	end

	// sample clock; >= guards against a rate change to a shorter period
	always_comb begin
		next_rate_cnt = rate_cnt + 24'h000001;
		next_conv_start = 1'b0;
		if (rate_cnt >= period_tab[rate_sel] - 24'h000001) begin
			next_rate_cnt = 24'h000000;
			next_conv_start = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rate_cnt <= 24'h000000;
			conv_start <= 1'b0;
			sample_x <= 16'h0000;
			sample_y <= 16'h0000;
			sample_z <= 16'h0000;
		end else begin
			rate_cnt <= next_rate_cnt;
			conv_start <= next_conv_start;
			// frozen while sending so a reply is never torn between samples
			if (conv_done && st != ST_SEND) begin
				sample_x <= axis_x;
				sample_y <= axis_y;
				sample_z <= axis_z;
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence s_fire_global;
		fire && is_global && p_cmd != CMD_POLL && p_cmd != CMD_CONT;
	endsequence
	property p_global_wait;
		s_fire_global ##1 st == ST_WAIT |->
			wait_ms == 12'(2 + $past(unit_identifier) * 40);
	endproperty
	a_global_wait: assert property (p_global_wait)
		else $error("global reply delay not scaled by identifier");
	property p_gen_wait;
		fire && !is_global && p_cmd == CMD_RATE |=> wait_ms == 12'h002;
	endproperty
	a_gen_wait: assert property (p_gen_wait)
		else $error("general reply delay wrong");
	property p_poll_wait;
		fire && !is_global && p_cmd == CMD_POLL |=>
			wait_ms == 12'h003 && kind == RP_DATA;
	endproperty
	a_poll_wait: assert property (p_poll_wait)
		else $error("poll reply delay wrong");
	property p_wait_hold;
		st == ST_WAIT && wait_ms > 12'h001 |=> st == ST_WAIT;
	endproperty
	a_wait_hold: assert property (p_wait_hold)
		else $error("reply started before delay ran out");
	property p_boot_start;
		$fell(sys_rst) |-> st == ST_BOOT && wait_ms == 12'h032;
	endproperty
	a_boot_start: assert property (p_boot_start)
		else $error("startup message not scheduled at 50 ms");
	property p_release;
		half_duplex && !tx_busy && st != ST_SEND |-> transmit_oe_n;
	endproperty
	a_release: assert property (p_release)
		else $error("line driven outside a reply");
	property p_drive;
		half_duplex && tx_busy |-> !transmit_oe_n;
	endproperty
	a_drive: assert property (p_drive)
		else $error("driver off while sending");
	property p_esc_stop;
		rx_valid && esc_seen && rx_data == CHAR_CR |=> !stream_on;
	endproperty
	a_esc_stop: assert property (p_esc_stop)
		else $error("escape sequence did not stop stream");
	property p_latch;
		conv_done && st != ST_SEND |=> sample_z == $past(axis_z);
	endproperty
	a_latch: assert property (p_latch)
		else $error("axis reading not captured");
	property p_rate_pulse;
		conv_start |-> rate_cnt == 24'h000000 ##1 !conv_start;
	endproperty
	a_rate_pulse: assert property (p_rate_pulse)
		else $error("sample strobe not single cycle");
	property p_load;
		!sys_rst && !loaded |=> unit_identifier == $past(nv_unit_identifier)
			&& baud_fast == $past(nv_baud_fast);
	endproperty
	a_load: assert property (p_load)
		else $error("stored settings not loaded");
endmodule

// ### dv/mag_host.sv
// host computer model on the serial line: 8N1 sender and receiver
`timescale 1ns/100ps
module mag_host #(
	parameter int DIV = 1041
) (
	// clock
	input wire logic ref_clk,
	// serial link
	input wire logic line_in,
	output logic line_out
);
	int now = 0;

	initial line_out = 1'b1;
	always @(posedge ref_clk) begin
		now <= now + 1;
	end

	// drives each bit on a rising edge; returns the stop bit middle cycle
	task automatic send_byte(input logic [7:0] b, output int stop_mid);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		@(posedge ref_clk);
		for (int i = 0; i < 10; i++) begin
			if (i == 9)
				stop_mid = now + DIV / 2;
			line_out <= frame[i];
			repeat (DIV) @(posedge ref_clk);
		end
	endtask

	// samples on falling edges so the device's launched bits have settled
	task automatic recv_byte(input int limit, output logic [7:0] b,
		output int start, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		b = 8'h00;
		start = 0;
		while (line_in !== 1'b0 && n < limit) begin
			@(negedge ref_clk);
			n++;
		end
		if (line_in === 1'b0) begin
			start = now;
			repeat (DIV / 2) @(negedge ref_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (DIV) @(negedge ref_clk);
				b[i] = line_in;
			end
			repeat (DIV) @(negedge ref_clk);
			ok = (line_in === 1'b1);
		end
	endtask
endmodule

// ### dv/tb_magnetometer_serial_command_timing.sv
// self-checking testbench for the magnetometer serial command engine
`timescale 1ns/100ps
module tb_magnetometer_serial_command_timing;
	import mag_pkg::*;
	// short millisecond keeps delays small; the bit period scales with it
	localparam int MS = 200;
	localparam int DIV = MS * MS_PER_S / BAUD_FAST;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic half_duplex = 1'b1;
	logic [6:0] nv_unit_identifier = 7'h05;
	logic [3:0] nv_rate_sel = 4'h3;
	logic nv_baud_fast = 1'b1;
	logic conv_done = 1'b0;
	logic [15:0] axis_x = 16'h1234;
	logic [15:0] axis_y = 16'h8001;
	logic [15:0] axis_z = 16'hFFFE;
	logic serial_receive_line, serial_transmit_line, transmit_oe_n;
	logic nv_write, baud_fast, conv_start, host_line, host_in;
	logic [6:0] unit_identifier;
	logic [3:0] rate_sel;
	int err_count = 0;
	int comparisons = 0;
	int nv_count = 0;
	int rel = 0;

	always #25 ref_clk = ~ref_clk;

	// shared line: in half duplex the device wins while its driver is on
	assign serial_receive_line = (half_duplex && !transmit_oe_n) ?
		serial_transmit_line : host_line;
	// released line rests at its pull-up level
	assign host_in = transmit_oe_n ? 1'b1 : serial_transmit_line;

	always @(posedge ref_clk) begin
		conv_done <= conv_start;
		if (nv_write === 1'b1)
			nv_count <= nv_count + 1;
	end

	mag_engine #(.MS_CYCLES(MS)) dut (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.serial_receive_line(serial_receive_line),
		.serial_transmit_line(serial_transmit_line),
		.transmit_oe_n(transmit_oe_n),
		.half_duplex(half_duplex),
		.nv_unit_identifier(nv_unit_identifier),
		.nv_rate_sel(nv_rate_sel),
		.nv_baud_fast(nv_baud_fast),
		.nv_write(nv_write),
		.unit_identifier(unit_identifier),
		.rate_sel(rate_sel),
		.baud_fast(baud_fast),
		.conv_start(conv_start),
		.conv_done(conv_done),
		.axis_x(axis_x),
		.axis_y(axis_y),
		.axis_z(axis_z)
	);

	mag_host #(.DIV(DIV)) host (
		.ref_clk(ref_clk),
		.line_in(host_in),
		.line_out(host_line)
	);

	task automatic stop_test();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_win(input int got, input int lo, input int hi);
		comparisons++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic send_cmd(input logic [7:0] q[$], output int mid);
		foreach (q[i])
			host.send_byte(q[i], mid);
	endtask

	// reply bytes, start latency from the command's last stop middle, driver
	task automatic expect_reply(input logic [7:0] q[$], input int mid,
		input int dly);
		logic [7:0] b;
		int st;
		logic ok;
		foreach (q[i]) begin
			host.recv_byte(i == 0 ? dly + 200 : 2 * DIV, b, st, ok);
			if (i == 0)
				check_win(st - mid, dly - 2, dly + 6);
			check_eq(16'(b), 16'(q[i]));
			check_eq(16'(ok), 16'h0001);
		end
		check_eq(16'(transmit_oe_n), 16'h0000);
		repeat (DIV / 2 + 4) @(negedge ref_clk);
		// full duplex keeps the driver on after the reply
		check_eq(16'(transmit_oe_n), 16'(half_duplex));
	endtask

	// spacing of conversion starts for a given sample rate
	task automatic t_period(input int sps);
		int n;
		n = 0;
		while (conv_start !== 1'b1 && n < 40000) begin
			@(negedge ref_clk);
			n++;
		end
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (conv_start !== 1'b1 && n < 40000);
		check_win(n, MS * 1000 / sps - 1, MS * 1000 / sps + 1);
	endtask

	task automatic t_startup();
		repeat (2) @(negedge ref_clk);
		check_eq(16'(unit_identifier), 16'h0005);
		check_eq(16'(rate_sel), 16'h0003);
		check_eq(16'(baud_fast), 16'h0001);
		// the message starts before two sample periods have passed
		expect_reply('{CHAR_O, CHAR_K, CHAR_CR}, rel,
			int'(STARTUP_MS) * MS);
		t_period(RATE_SPS[3]);
	endtask

	task automatic t_poll();
		int mid;
		check_eq(16'(transmit_oe_n), 16'h0001);
		send_cmd('{CHAR_STAR, CHAR_ZERO, CHAR_ZERO + 8'h05, CMD_POLL,
			CHAR_CR}, mid);
		expect_reply('{axis_x[15:8], axis_x[7:0], axis_y[15:8], axis_y[7:0],
			axis_z[15:8], axis_z[7:0], CHAR_CR}, mid,
			int'(RESP_POLL_MS) * MS);
	endtask

	task automatic t_global_rate();
		int mid;
		send_cmd('{CHAR_STAR, CHAR_NINE, CHAR_NINE, CMD_RATE, CHAR_NINE,
			CHAR_CR}, mid);
		expect_reply('{CHAR_O, CHAR_K, CHAR_CR}, mid,
			(int'(RESP_GEN_MS) + 5 * int'(GLOBAL_STEP_MS)) * MS);
		check_eq(16'(rate_sel), 16'h0009);
		check_eq(16'(nv_count), 16'h0001);
		t_period(RATE_SPS[9]);
	endtask

	// continuous output on the full-duplex line, stopped by escape, return
	task automatic t_stream();
		int mid;
		int lows;
		@(posedge ref_clk);
		half_duplex <= 1'b0;
		@(negedge ref_clk);
		check_eq(16'(transmit_oe_n), 16'h0000);
		send_cmd('{CHAR_STAR, CHAR_ZERO, CHAR_ZERO + 8'h05, CMD_CONT,
			CHAR_CR}, mid);
		// a sample is already waiting, so the stream starts at once
		expect_reply('{axis_x[15:8], axis_x[7:0], axis_y[15:8], axis_y[7:0],
			axis_z[15:8], axis_z[7:0], CHAR_CR}, mid, 1);
		host.send_byte(CHAR_ESC, mid);
		host.send_byte(CHAR_CR, mid);
		// a reply already under way may still finish
		repeat (10 * DIV * 8) @(negedge ref_clk);
		lows = 0;
		repeat (3000) begin
			@(negedge ref_clk);
			if (serial_transmit_line !== 1'b1)
				lows++;
		end
		check_eq(16'(lows), 16'h0000);
	endtask

	initial begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rel = host.now;
		t_startup();
		t_poll();
		t_global_rate();
		t_stream();
		stop_test();
	end

	// whole run is near 70k cycles; a hang ends here instead
	initial begin
		repeat (95000) @(posedge ref_clk);
		err_count++;
		stop_test();
	end
endmodule
